// ==== design/udtcc_defs.vh ====
// register map, field positions, codes and reset values of the up/down timer block
`ifndef UDTCC_DEFS_VH
`define UDTCC_DEFS_VH
`define UDTCC_CNT_W 16
`define UDTCC_CTRL_OFS 12'h000
`define UDTCC_COUNT_OFS 12'h004
`define UDTCC_CH_BASE 12'h010
`define UDTCC_CH_SHIFT 3
`define UDTCC_CCR_BIT 2
// main control register fields
`define UDTCC_MODE_LSB 0
`define UDTCC_LEN_LSB 2
`define UDTCC_GRP_LSB 4
`define UDTCC_CLR_BIT 6
`define UDTCC_OVF_BIT 8
// channel control register fields
`define UDTCC_CAP_BIT 0
`define UDTCC_SRC_LSB 1
`define UDTCC_EDGE_LSB 3
`define UDTCC_SYNC_BIT 5
`define UDTCC_LD_LSB 6
`define UDTCC_FLAG_BIT 8
`define UDTCC_COV_BIT 9
`define UDTCC_LVL_BIT 10
// count modes
`define UDTCC_MODE_STOP 2'h0
`define UDTCC_MODE_UP 2'h1
`define UDTCC_MODE_CONT 2'h2
`define UDTCC_MODE_UPDN 2'h3
// maximum counts per length
`define UDTCC_MAX_8 16'h00FF
`define UDTCC_MAX_10 16'h03FF
`define UDTCC_MAX_12 16'h0FFF
`define UDTCC_MAX_16 16'hFFFF
// latch load events
`define UDTCC_LD_IMM 2'h0
`define UDTCC_LD_ZERO 2'h1
`define UDTCC_LD_ZPER 2'h2
`define UDTCC_LD_OLD 2'h3
// capture edges
`define UDTCC_EDGE_RISE 2'h1
`define UDTCC_EDGE_FALL 2'h2
`define UDTCC_EDGE_BOTH 2'h3
// capture sources
`define UDTCC_SRC_A 2'h0
`define UDTCC_SRC_B 2'h1
`define UDTCC_SRC_GND 2'h2
// latch groupings
`define UDTCC_GRP_PAIR 2'h1
`define UDTCC_GRP_TRIPLE 2'h2
`define UDTCC_GRP_ALL 2'h3
// reset values
`define UDTCC_CNT_RST 16'h0000
`define UDTCC_CCTL_RST 8'h00
`endif

// ==== design/udtcc_timer.v ====
// up/down timer with capture/compare channels behind an AHB-Lite slave
//
// Chosen here: the placing of the registers and the AHB-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
`include "udtcc_defs.vh"
//////////////////////////////////////////////////////////////////////////////
module udtcc_timer #(
  parameter NCH = 7
) (
  input wire clock,
  input wire sys_rst,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output wire hresp,
  output wire [31:0] hrdata,
  input wire [NCH-1:0] snapshot_input_a,
  input wire [NCH-1:0] snapshot_input_b,
  output wire [NCH-1:0] match_signal,
  output wire [NCH-1:0] channel_flag,
  output wire overflow_flag
);

  localparam CW = `UDTCC_CNT_W;

  // controlling channel of channel i under grouping g
  function [2:0] ctl_of;
    input [2:0] i;
    input [1:0] g;
    begin
      case (g)
        `UDTCC_GRP_PAIR: ctl_of = (i == 3'h0) ? 3'h0 : (i[0] ? i : i - 3'h1);
        `UDTCC_GRP_TRIPLE: ctl_of = (i == 3'h0) ? 3'h0 : ((i <= 3'h3) ? 3'h1 : 3'h4);
        `UDTCC_GRP_ALL: ctl_of = 3'h1;
        default: ctl_of = i;
      endcase
    end
  endfunction

  function [CW-1:0] max_of;
    input [1:0] len;
    begin
      case (len)
        2'h0: max_of = `UDTCC_MAX_16;
        2'h1: max_of = `UDTCC_MAX_12;
        2'h2: max_of = `UDTCC_MAX_10;
        default: max_of = `UDTCC_MAX_8;
      endcase
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // bus slave
  reg wr_q;
  reg [11:0] wad_q;
  reg [31:0] rdata_q;
  reg [31:0] rd_d;
  wire acc = hsel && hready && htrans[1];
  wire [11:0] rad = haddr[11:0];
  localparam [31:0] CH_TOP_W = `UDTCC_CH_BASE + (NCH << `UDTCC_CH_SHIFT);
  wire [11:0] ch_top = CH_TOP_W[11:0];
  wire rd_ch_hit = (rad >= `UDTCC_CH_BASE) && (rad < ch_top);
  wire [11:0] rd_rel = rad - `UDTCC_CH_BASE;
  wire [2:0] rd_ch = rd_rel[`UDTCC_CH_SHIFT+2:`UDTCC_CH_SHIFT];
  wire wr_ch_hit = wr_q && (wad_q >= `UDTCC_CH_BASE) && (wad_q < ch_top);
  wire [11:0] wr_rel = wad_q - `UDTCC_CH_BASE;
  wire [2:0] wr_ch = wr_rel[`UDTCC_CH_SHIFT+2:`UDTCC_CH_SHIFT];
  wire wr_ctrl = wr_q && (wad_q == `UDTCC_CTRL_OFS);
  wire wr_cnt = wr_q && (wad_q == `UDTCC_COUNT_OFS);

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdata_q;

  always @(posedge clock)
  begin
    if (sys_rst)
    begin
      wr_q <= 1'b0;
      wad_q <= 12'h000;
      rdata_q <= 32'h00000000;
    end
    else
    begin
      wr_q <= acc && hwrite;
      wad_q <= {haddr[11:2], 2'h0};
      if (acc && !hwrite)
        rdata_q <= rd_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // counter
  reg [1:0] mode_q;
  reg [1:0] len_q;
  reg [1:0] grp_q;
  reg ovf_q;
  reg dir_q;
  reg [CW-1:0] cnt_q;
  reg [CW-1:0] cnt_d;
  reg dir_d;
  reg ovf_evt;
  wire [CW*NCH-1:0] lat_w;
  wire [CW*NCH-1:0] buf_w;
  wire [2*NCH-1:0] ld_w;
  wire [NCH-1:0] pend_w;
  wire [11*NCH-1:0] cctl_w;
  wire [CW-1:0] period = lat_w[CW-1:0];
  wire [CW-1:0] maxc = max_of(len_q);
  wire clr = wr_ctrl && hwdata[`UDTCC_CLR_BIT];
  // software writes to the counter are not counts and raise no events
  wire step = (mode_q != `UDTCC_MODE_STOP) && !clr && !wr_cnt && (cnt_d != cnt_q);

  always @*
  begin
    cnt_d = cnt_q;
    dir_d = dir_q;
    ovf_evt = 1'b0;
    case (mode_q)
      `UDTCC_MODE_UP:
      begin
        if (period == `UDTCC_CNT_RST)
          cnt_d = `UDTCC_CNT_RST;
        else if (cnt_q >= period)
        begin
          cnt_d = `UDTCC_CNT_RST;
          ovf_evt = (cnt_q == period);
        end
        else
          cnt_d = cnt_q + 16'h0001;
      end
      `UDTCC_MODE_CONT:
      begin
        if (cnt_q >= maxc)
        begin
          cnt_d = `UDTCC_CNT_RST;
          ovf_evt = 1'b1;
        end
        else
          cnt_d = cnt_q + 16'h0001;
      end
      `UDTCC_MODE_UPDN:
      begin
        if (period > maxc)
        begin
          dir_d = 1'b0;
          if (cnt_q >= maxc)
          begin
            cnt_d = `UDTCC_CNT_RST;
            ovf_evt = 1'b1;
          end
          else
            cnt_d = cnt_q + 16'h0001;
        end
        else if (period == `UDTCC_CNT_RST)
        begin
          cnt_d = `UDTCC_CNT_RST;
          dir_d = 1'b0;
        end
        else if (dir_q) // descent ignores the period until zero
        begin
          if (cnt_q == `UDTCC_CNT_RST)
          begin
            cnt_d = 16'h0001;
            dir_d = 1'b0;
          end
          else
          begin
            cnt_d = cnt_q - 16'h0001;
            if (cnt_q == 16'h0001)
            begin
              dir_d = 1'b0;
              ovf_evt = 1'b1;
            end
          end
        end
        else if (cnt_q >= period)
        begin
          cnt_d = cnt_q - 16'h0001;
          dir_d = (cnt_q != 16'h0001);
          ovf_evt = (cnt_q == 16'h0001);
        end
        else
          cnt_d = cnt_q + 16'h0001;
      end
      default:
      begin
        cnt_d = cnt_q;
        dir_d = dir_q; // direction kept while stopped
      end
    endcase
  end

  always @(posedge clock)
  begin
    if (sys_rst)
    begin
      mode_q <= `UDTCC_MODE_STOP;
      len_q <= 2'h0;
      grp_q <= 2'h0;
      ovf_q <= 1'b0;
      dir_q <= 1'b0;
      cnt_q <= `UDTCC_CNT_RST;
    end
    else
    begin
      if (wr_ctrl)
      begin
        mode_q <= hwdata[`UDTCC_MODE_LSB +: 2];
        len_q <= hwdata[`UDTCC_LEN_LSB +: 2];
        grp_q <= hwdata[`UDTCC_GRP_LSB +: 2];
      end
      // a new overflow wins over a clear in the same cycle
      ovf_q <= (step && ovf_evt) || (ovf_q && !(wr_ctrl && hwdata[`UDTCC_OVF_BIT]));
      if (clr)
      begin
        cnt_q <= `UDTCC_CNT_RST;
        dir_q <= 1'b0;
      end
      else if (wr_cnt)
        cnt_q <= hwdata[CW-1:0] & maxc;
      else
      begin
        cnt_q <= cnt_d;
        dir_q <= dir_d;
      end
    end
  end

  assign overflow_flag = ovf_q;

  //////////////////////////////////////////////////////////////////////////////
  // capture/compare channels
  genvar gi;
  generate
    for (gi = 0; gi < NCH; gi = gi + 1)
    begin : ch
      reg [CW-1:0] buf_q;
      reg [CW-1:0] lat_q;
      reg [7:0] ctl_q;
      reg flag_q;
      reg cov_q;
      reg unread_q;
      reg prev_q;
      reg edge_q;
      reg match_q;
      reg pend_q;
      reg [2:0] ctl_c;
      reg grouped;
      reg ready;
      reg evt;
      integer j;
      wire [31:0] gi_w = gi;
      wire [2:0] me = gi_w[2:0];
      wire capm = ctl_q[`UDTCC_CAP_BIT];
      wire [1:0] src = ctl_q[`UDTCC_SRC_LSB +: 2];
      wire [1:0] edg = ctl_q[`UDTCC_EDGE_LSB +: 2];
      // a software capture is a toggle of the low source bit between the fixed levels
      wire lvl = (src == `UDTCC_SRC_A) ? snapshot_input_a[gi] :
                 (src == `UDTCC_SRC_B) ? snapshot_input_b[gi] :
                 (src == `UDTCC_SRC_GND) ? 1'b0 : 1'b1;
      wire edge_now = ((edg == `UDTCC_EDGE_RISE) && lvl && !prev_q) ||
                      ((edg == `UDTCC_EDGE_FALL) && !lvl && prev_q) ||
                      ((edg == `UDTCC_EDGE_BOTH) && (lvl != prev_q));
      wire cap_evt = capm && (ctl_q[`UDTCC_SYNC_BIT] ? edge_q : edge_now);
      wire cmp_evt = !capm && step && (cnt_d == lat_q);
      wire wr_me = wr_ch_hit && (wr_ch == me);
      wire wr_buf = wr_me && wad_q[`UDTCC_CCR_BIT];
      wire wr_ctl = wr_me && !wad_q[`UDTCC_CCR_BIT];
      wire rd_buf = acc && !hwrite && rd_ch_hit && (rd_ch == me) && rad[`UDTCC_CCR_BIT];
      wire [1:0] sel_e = ld_w[ctl_c*2 +: 2];
      wire [CW-1:0] lat_c = lat_w[ctl_c*CW +: CW];
      wire imm = (sel_e == `UDTCC_LD_IMM);
      wire load = !imm && ready && evt;

      always @*
      begin
        ctl_c = ctl_of(me, grp_q);
        grouped = (ld_w[ctl_c*2 +: 2] != `UDTCC_LD_IMM);
        ready = 1'b1;
        for (j = 0; j < NCH; j = j + 1)
        begin
          if ((grouped && (ctl_of(j[2:0], grp_q) == ctl_c)) || (j == gi))
            ready = ready && pend_w[j];
        end
        case (sel_e)
          `UDTCC_LD_ZERO: evt = step && (cnt_d == `UDTCC_CNT_RST);
          `UDTCC_LD_ZPER: evt = step && ((cnt_d == `UDTCC_CNT_RST) ||
                                ((mode_q == `UDTCC_MODE_UPDN) && (cnt_d == period)));
          `UDTCC_LD_OLD: evt = step && (cnt_d == lat_c);
          default: evt = 1'b0;
        endcase
      end

      always @(posedge clock)
      begin
        if (sys_rst)
        begin
          buf_q <= `UDTCC_CNT_RST;
          lat_q <= `UDTCC_CNT_RST;
          ctl_q <= `UDTCC_CCTL_RST;
          flag_q <= 1'b0;
          cov_q <= 1'b0;
          unread_q <= 1'b0;
          prev_q <= 1'b0;
          edge_q <= 1'b0;
          match_q <= 1'b0;
          pend_q <= 1'b0;
        end
        else
        begin
          prev_q <= lvl;
          edge_q <= edge_now;
          match_q <= cmp_evt;
          if (wr_ctl)
            ctl_q <= hwdata[7:0];
          if (cap_evt)
            buf_q <= cnt_q;
          else if (wr_buf)
            buf_q <= hwdata[CW-1:0];
          if (wr_buf && imm)
            lat_q <= hwdata[CW-1:0];
          else if (load)
            lat_q <= buf_q;
          pend_q <= (wr_buf && !imm) || (pend_q && !load);
          // set wins over a clear written in the same cycle
          flag_q <= cap_evt || cmp_evt ||
                    (flag_q && !(wr_ctl && hwdata[`UDTCC_FLAG_BIT]));
          cov_q <= (cap_evt && unread_q) ||
                   (cov_q && !(wr_ctl && hwdata[`UDTCC_COV_BIT]));
          unread_q <= cap_evt || (unread_q && !rd_buf);
        end
      end

      assign lat_w[gi*CW +: CW] = lat_q;
      assign buf_w[gi*CW +: CW] = buf_q;
      assign ld_w[gi*2 +: 2] = ctl_q[`UDTCC_LD_LSB +: 2];
      assign pend_w[gi] = pend_q;
      assign cctl_w[gi*11 +: 11] = {lvl, cov_q, flag_q, ctl_q};
      assign match_signal[gi] = match_q;
      assign channel_flag[gi] = flag_q;
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // read mux; active latches are deliberately not readable
  always @*
  begin
    rd_d = 32'h00000000;
    if (rad == `UDTCC_CTRL_OFS)
    begin
      rd_d[`UDTCC_MODE_LSB +: 2] = mode_q;
      rd_d[`UDTCC_LEN_LSB +: 2] = len_q;
      rd_d[`UDTCC_GRP_LSB +: 2] = grp_q;
      rd_d[`UDTCC_OVF_BIT] = ovf_q;
    end
    else if (rad == `UDTCC_COUNT_OFS)
      rd_d[CW-1:0] = cnt_q;
    else if (rd_ch_hit && rad[`UDTCC_CCR_BIT])
      rd_d[CW-1:0] = buf_w[rd_ch*CW +: CW];
    else if (rd_ch_hit)
      rd_d[10:0] = cctl_w[rd_ch*11 +: 11];
  end

endmodule // udtcc_timer
`default_nettype wire

// ==== testbench/udtcc_monitor.sv ====
// assertion checker on the ports of the up/down timer block
`timescale 1ns/10ps
`default_nettype none
module udtcc_monitor #(
  parameter NCH = 7
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire logic [NCH-1:0] match_signal,
  input wire logic [NCH-1:0] channel_flag,
  input wire logic overflow_flag
);
  logic rd;
  logic wr_d;
  logic wr_q;
  assign rd = hsel && hready && htrans[1] && !hwrite;
  assign wr_d = hsel && hready && htrans[1] && hwrite;
  // any write may clear a flag one edge later, so holds are only claimed without one
  always @(posedge clock)
  begin
    if (sys_rst)
      wr_q <= 1'b0;
    else
      wr_q <= wr_d;
  end
  //////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  property p_okay; hreadyout && !hresp; endproperty
  property p_unmapped; rd && haddr[11:0] == 12'h008 |=> hrdata == 32'h0; endproperty
  property p_clr_zero; rd && haddr[11:0] == 12'h000 |=> !hrdata[6]; endproperty
  property p_cnt_rng; rd && haddr[11:0] == 12'h004 |=> hrdata[31:16] == 16'h0; endproperty
  property p_hold; !rd |=> $stable(hrdata); endproperty
  property p_match_flag; |match_signal |-> (channel_flag & match_signal) == match_signal; endproperty
  property p_match_pulse; |match_signal |=> (match_signal & $past(match_signal)) == '0; endproperty
  property p_ovf_hold; overflow_flag && !wr_q |=> overflow_flag; endproperty
  property p_flag_hold; !wr_q |=> (channel_flag & $past(channel_flag)) == $past(channel_flag); endproperty
  a_okay: assert property (p_okay) else $error("bus not ready or not okay");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  a_clr_zero: assert property (p_clr_zero) else $error("clear bit reads one");
  a_cnt_rng: assert property (p_cnt_rng) else $error("count above 16 bits");
  a_hold: assert property (p_hold) else $error("read data moved without a read");
  a_match_flag: assert property (p_match_flag) else $error("match without flag");
  a_match_pulse: assert property (p_match_pulse) else $error("match longer than a cycle");
  a_ovf_hold: assert property (p_ovf_hold) else $error("overflow flag dropped");
  a_flag_hold: assert property (p_flag_hold) else $error("channel flag dropped");
  c_ovf: cover property ($rose(overflow_flag));
  c_match: cover property (match_signal[0]);
  c_capt: cover property ($rose(channel_flag[3]));
endmodule // udtcc_monitor
bind udtcc_timer udtcc_monitor #(.NCH(NCH)) u_udtcc_monitor (.clock(clock), .sys_rst(sys_rst),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
  .hresp(hresp), .hrdata(hrdata), .match_signal(match_signal), .channel_flag(channel_flag),
  .overflow_flag(overflow_flag));
`default_nettype wire

// ==== testbench/udtcc_far.sv ====
// model of the capture input sources facing the timer
`timescale 1ns/10ps
`default_nettype none
module udtcc_far #(
  parameter NCH = 7
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [NCH-1:0] lvl_req,
  output logic [NCH-1:0] snapshot_input_a,
  output logic [NCH-1:0] snapshot_input_b
);
  always @(posedge clock)
  begin
    if (sys_rst)
    begin
      snapshot_input_a <= '0;
      snapshot_input_b <= '0;
    end
    else
    begin
      snapshot_input_a <= lvl_req;
      // unused source keeps moving so a wrong select cannot read a steady level
      snapshot_input_b <= ~snapshot_input_b;
    end
  end
endmodule // udtcc_far
`default_nettype wire

// ==== testbench/tb.sv ====
// self-checking bench for the up/down timer block
`timescale 1ns/10ps
`default_nettype none
module tb;
  localparam NCH = 7;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout, hresp, overflow_flag, ovf_prev;
  logic [31:0] hrdata, r, v;
  logic [NCH-1:0] snapshot_input_a, snapshot_input_b, match_signal, channel_flag;
  logic [NCH-1:0] lvl_req = '0;
  logic [31:0] mask [4] = '{32'hFFFF, 32'h0FFF, 32'h03FF, 32'h00FF};
  int err_total = 0;
  int compares = 0;
  int seed = 21545;
  int cyc = 0;
  int ovf_gap = 0;
  int since [NCH];
  int gap [NCH];
  int rel [NCH];
  logic [31:0] cap_q [$];
  udtcc_timer #(.NCH(NCH)) u_udtcc_timer (.clock(clock), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .snapshot_input_a(snapshot_input_a),
    .snapshot_input_b(snapshot_input_b), .match_signal(match_signal), .channel_flag(channel_flag),
    .overflow_flag(overflow_flag));
  udtcc_far #(.NCH(NCH)) u_udtcc_far (.clock(clock), .sys_rst(sys_rst), .lvl_req(lvl_req),
    .snapshot_input_a(snapshot_input_a), .snapshot_input_b(snapshot_input_b));
  initial
  begin
    forever #4 clock = ~clock;
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      err_total++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic ahb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {20'h0, a};
    hwrite <= wr;
    @(posedge clock);
    while (hreadyout !== 1'b1) @(posedge clock);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clock);
    while (hreadyout !== 1'b1) @(posedge clock);
    r = hrdata;
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clock);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  // spacing of events measured in cycles, independent of bus latency
  always @(posedge clock)
  begin
    cyc++;
    for (int i = 0; i < NCH; i++)
    begin
      since[i]++;
      if (match_signal[i] === 1'b1)
      begin
        gap[i] = since[i];
        since[i] = 0;
        rel[i] = since[0];
      end
    end
    if (overflow_flag === 1'b1 && ovf_prev !== 1'b1)
      ovf_gap = since[0];
    ovf_prev = overflow_flag;
    if (cyc > 20000)
    begin
      err_total++;
      give_verdict();
    end
  end
  initial
  begin
    repeat (6) @(posedge clock);
    sys_rst <= 1'b0;
    ahb(1'b0, 12'h000, 32'h0);
    chk(r, 32'h0);
    ahb(1'b0, 12'h008, 32'h0);
    chk(r, 32'h0);
    ahb(1'b1, 12'h014, 32'hC);
    ahb(1'b1, 12'h000, 32'h3);
    idle(80);
    chk(gap[0], 32'h18);
    chk(ovf_gap, 32'hC);
    ovf_gap = 0;
    ahb(1'b1, 12'h000, 32'h103);
    idle(60);
    chk(ovf_gap, 32'hC);
    // 8-bit length with a period beyond its maximum
    ahb(1'b1, 12'h000, 32'hF);
    ahb(1'b1, 12'h014, 32'h1FF);
    ahb(1'b1, 12'h01C, 32'h10);
    idle(700);
    chk(gap[1], 32'h100);
    ahb(1'b1, 12'h000, 32'h40);
    ahb(1'b0, 12'h004, 32'h0);
    chk(r, 32'h0);
    for (int l = 0; l < 4; l++)
    begin
      ahb(1'b1, 12'h000, 32'(l << 2));
      v = $random(seed);
      ahb(1'b1, 12'h004, v);
      ahb(1'b0, 12'h004, 32'h0);
      chk(r, v & mask[l]);
    end
    cap_q.push_back(v & 32'hFF);
    // capture by toggling the supply/ground source
    ahb(1'b1, 12'h020, 32'h1D);
    ahb(1'b1, 12'h020, 32'h1F);
    idle(4);
    ahb(1'b0, 12'h024, 32'h0);
    chk(r, cap_q.pop_front());
    chk({31'h0, channel_flag[2]}, 32'h1);
    ahb(1'b0, 12'h020, 32'h0);
    chk(r & 32'h600, 32'h400);
    ahb(1'b1, 12'h020, 32'h1D);
    ahb(1'b1, 12'h020, 32'h1F);
    idle(4);
    ahb(1'b0, 12'h020, 32'h0);
    chk(r & 32'h200, 32'h200);
    ahb(1'b1, 12'h020, 32'h21F);
    ahb(1'b0, 12'h020, 32'h0);
    chk(r & 32'h200, 32'h0);
    // pin capture, rising edge only, synchronised
    ahb(1'b1, 12'h028, 32'h29);
    v = $random(seed);
    ahb(1'b1, 12'h004, v);
    cap_q.push_back(v & 32'hFF);
    lvl_req[3] <= 1'b1;
    idle(6);
    ahb(1'b0, 12'h02C, 32'h0);
    chk(r, cap_q[0]);
    v = $random(seed);
    ahb(1'b1, 12'h004, v);
    lvl_req[3] <= 1'b0;
    idle(6);
    ahb(1'b0, 12'h02C, 32'h0);
    chk(r, cap_q.pop_front());
    chk({31'h0, channel_flag[3]}, 32'h1);
    // pair 5-6 under channel 5, load at count to zero once both buffers are written
    ahb(1'b1, 12'h000, 32'h50);
    ahb(1'b1, 12'h038, 32'h40);
    ahb(1'b1, 12'h040, 32'h0);
    ahb(1'b1, 12'h03C, 32'h20);
    ahb(1'b1, 12'h014, 32'h40);
    ahb(1'b1, 12'h000, 32'h11);
    idle(150);
    chk(rel[5], 32'h1);
    ahb(1'b1, 12'h044, 32'h30);
    idle(150);
    chk(rel[5], 32'h21);
    chk(rel[6], 32'h31);
    // controller with load select zero: member loads on its own write
    ahb(1'b1, 12'h000, 32'h10);
    ahb(1'b1, 12'h038, 32'h0);
    ahb(1'b1, 12'h040, 32'h140);
    ahb(1'b1, 12'h044, 32'h10);
    ahb(1'b1, 12'h004, 32'hF);
    chk({31'h0, channel_flag[6]}, 32'h0);
    ahb(1'b1, 12'h000, 32'h11);
    idle(4);
    chk({31'h0, channel_flag[6]}, 32'h1);
    give_verdict();
  end
endmodule // tb
`default_nettype wire
